// ### src/rmf_formatter.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "rmf_consts.svh"
module rmf_formatter
   import rmf_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rdReq,
   input wire logic rdSelDreg,
   input wire logic rdSign,
   input wire logic [23:0] rdDigits,
   input wire logic [2:0] rdPoint,
   input wire logic [5:0] rdExp,
   input wire logic rdHighZ,
   input wire logic [31:0] rdBin4,
   input wire logic [15:0] rdHsValue,
   input wire logic rdOverPos,
   input wire logic rdOverNeg,
   input wire logic rdResist,
   input wire logic limitActive,
   input wire logic [1:0] limitCode,
   input wire logic [7:0] dregMajor,
   input wire logic [3:0] dregMinor,
   output logic reqReady,
   output logic [7:0] busData,
   output logic busValid,
   output logic busEoi,
   input wire logic busReady,
   input wire logic devClear,
   input wire logic resetChar,
   input wire logic clearReqChar,
   input wire logic getCmd,
   input wire logic trigBusy,
   output logic trigStart,
   output logic measAbort,
   input wire logic evOutReady,
   input wire logic evOverrange,
   input wire logic evError,
   input wire logic evEndBurst,
   input wire logic evHighPeak,
   input wire logic evLowPeak,
   input wire logic evHigh,
   input wire logic evPass,
   input wire logic evLow,
   input wire logic evLfac,
   output logic srqLine,
   output logic [7:0] statusByte,
   output logic externalTriggerMode,
   output logic highSpeedMode,
   output logic lineFeedEnable,
   output logic endIdentifyEnable,
   output logic binaryOutputSelect
);
   rmf_ctrl_t ctrl, next_ctrl;
   logic [11:0] mask, next_mask;
   logic [4:0] flags, next_flags;
   logic dataPend, next_dataPend;
   logic trigStartQ, next_trigStart;
   logic abortQ, next_abort;
   logic access, wrCtrl, wrMask, mapped;
   logic clearAny, loadRead;
   logic [4:0] setV, clrV;
   logic [23:0] digs;
   logic [5:0] expMag, expQ;
   logic [3:0] expUnits;
   logic expTens;
   rmf_msg_t asciiMsg, msg;
   logic [3:0] len;
   logic [7:0] eol;
   logic [15:0] hsWord;
   int k;

   rmf_msg_if mi ();

   rmf_byte_sender u_sender (
      .clock(clock),
      .rstn(rstn),
      .mi(mi.snk),
      .busData(busData),
      .busValid(busValid),
      .busEoi(busEoi),
      .busReady(busReady)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, unmapped offsets answer with an error
   assign access = psel && penable;
   assign pready = 1'b1;
   assign mapped = (paddr == `RMF_OFS_CTRL) || (paddr == `RMF_OFS_MASK) ||
                   (paddr == `RMF_OFS_STAT);
   assign pslverr = access && !mapped;
   assign wrCtrl = access && pwrite && (paddr == `RMF_OFS_CTRL);
   assign wrMask = access && pwrite && (paddr == `RMF_OFS_MASK);

   // Read mux; the status register is read only
   always_comb begin
      prdata = 32'h0000_0000;
      if (access && !pwrite) begin
         case (paddr)
            `RMF_OFS_CTRL: prdata = {27'h0, ctrl};
            `RMF_OFS_MASK: prdata = {20'h0, mask};
            `RMF_OFS_STAT: prdata = {24'h0, statusByte};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and mask registers
   assign clearAny = devClear || resetChar;

   // A clear beats a same-cycle write: the device must land on defaults
   always_comb begin
      next_ctrl = ctrl;
      next_mask = mask;
      if (wrCtrl) begin
         next_ctrl = rmf_ctrl_t'(pwdata[4:0]);
      end
      if (wrMask) begin
         // Each write shifts in one octal digit, so short codes just work
         if (pwdata[`RMF_MASK_FIRST]) begin
            next_mask = {9'h000, pwdata[2:0]};
         end else begin
            next_mask = {mask[8:0], pwdata[2:0]};
         end
      end
      if (getCmd) begin
         next_ctrl.extTrig = 1'b1;
      end
      if (clearAny) begin
         next_ctrl = rmf_ctrl_t'(`RMF_CTRL_RESET);
         next_mask = `RMF_MASK_RESET;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl <= rmf_ctrl_t'(`RMF_CTRL_RESET);
         mask <= `RMF_MASK_RESET;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
      end
   end

   assign externalTriggerMode = ctrl.extTrig;
   assign highSpeedMode = ctrl.highSpeed;
   assign lineFeedEnable = ctrl.lfEn;
   assign endIdentifyEnable = ctrl.eoiEn;
   assign binaryOutputSelect = ctrl.binSel;

   ////////////////////////////////////////////////////////////////////////
   // ASCII reading message
   assign eol = ctrl.lfEn ? `RMF_CH_LF : `RMF_CH_CR;

   // Exponent is folded to a multiple of three inside the legal span
   always_comb begin
      expMag = rdExp[5] ? 6'(6'h00 - rdExp) : rdExp;
      if (expMag > `RMF_EXP_MAX) begin
         expMag = `RMF_EXP_MAX;
      end
      expQ = 6'(expMag - (expMag % 6'd3));
      expTens = (expQ >= 6'd10);
      expUnits = expTens ? 4'(expQ - 6'd10) : expQ[3:0];
   end

   // Data field: digits with the point slotted in after rdPoint digits
   always_comb begin
      digs = rdHighZ ? {4'h0, rdDigits[19:0]} : rdDigits;
      asciiMsg = '0;
      k = 0;
      asciiMsg[0] = rdSign ? `RMF_CH_MINUS : `RMF_CH_PLUS;
      for (int i = 0; i < 7; i++) begin
         if (i == int'(rdPoint)) begin
            asciiMsg[i + 1] = `RMF_CH_POINT;
         end else if (k < 6) begin
            asciiMsg[i + 1] = `RMF_CH_ZERO | {4'h0, digs[4 * (5 - k) +: 4]};
            k = k + 1;
         end else begin
            asciiMsg[i + 1] = `RMF_CH_ZERO;
         end
      end
      asciiMsg[8] = `RMF_CH_EXP;
      asciiMsg[9] = rdExp[5] ? `RMF_CH_MINUS : `RMF_CH_PLUS;
      asciiMsg[10] = `RMF_CH_ZERO | {7'h00, expTens};
      asciiMsg[11] = `RMF_CH_ZERO | {4'h0, expUnits};
      asciiMsg[12] = `RMF_CH_CR;
      asciiMsg[13] = `RMF_CH_LF;
   end

   ////////////////////////////////////////////////////////////////////////
   // High-speed word; the listener takes byte 1 (low) first
   always_comb begin
      hsWord = rdHsValue;
      if (rdResist) begin
         hsWord[15] = 1'b1;
      end
      if (rdOverPos) begin
         hsWord = `RMF_HS_OVR_POS;
      end else if (rdOverNeg) begin
         hsWord = `RMF_HS_OVR_NEG;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Message select; the reset character wins over every reading
   always_comb begin
      msg = '0;
      len = 4'd1;
      if (clearAny) begin
         msg[0] = `RMF_CH_RESET;
         len = 4'd1;
      end else if (rdSelDreg) begin
         // Register number such as 3.1 or 11.2, tens only when present
         if (dregMajor[7:4] != 4'h0) begin
            msg[0] = `RMF_CH_ZERO | {4'h0, dregMajor[7:4]};
            msg[1] = `RMF_CH_ZERO | {4'h0, dregMajor[3:0]};
            msg[2] = `RMF_CH_POINT;
            msg[3] = `RMF_CH_ZERO | {4'h0, dregMinor};
            msg[4] = `RMF_CH_CR;
            msg[5] = `RMF_CH_LF;
            len = ctrl.lfEn ? 4'd6 : 4'd5;
         end else begin
            msg[0] = `RMF_CH_ZERO | {4'h0, dregMajor[3:0]};
            msg[1] = `RMF_CH_POINT;
            msg[2] = `RMF_CH_ZERO | {4'h0, dregMinor};
            msg[3] = `RMF_CH_CR;
            msg[4] = `RMF_CH_LF;
            len = ctrl.lfEn ? 4'd5 : 4'd4;
         end
      end else if (limitActive) begin
         if (ctrl.binSel) begin
            // 1 high, 2 pass, other low
            case (limitCode)
               2'd1: msg[0] = `RMF_LIM_HIGH;
               2'd2: msg[0] = `RMF_LIM_PASS;
               default: msg[0] = `RMF_LIM_LOW;
            endcase
            len = 4'd1;
         end else begin
            case (limitCode)
               2'd1: msg[1:0] = {8'h32, `RMF_CH_PLUS};
               2'd2: msg[1:0] = {8'h31, `RMF_CH_PLUS};
               default: msg[1:0] = {8'h31, `RMF_CH_MINUS};
            endcase
            msg[2] = `RMF_CH_CR;
            msg[3] = `RMF_CH_LF;
            len = ctrl.lfEn ? 4'd4 : 4'd3;
         end
      end else if (ctrl.highSpeed) begin
         msg[0] = hsWord[7:0];
         msg[1] = hsWord[15:8];
         len = 4'd2;
      end else if (ctrl.binSel) begin
         // Mantissa and exponent arrive packed; sent high byte first
         msg[0] = rdBin4[31:24];
         msg[1] = rdBin4[23:16];
         msg[2] = rdBin4[15:8];
         msg[3] = rdBin4[7:0];
         len = 4'd4;
      end else begin
         msg = asciiMsg;
         msg[13] = eol;
         len = ctrl.lfEn ? `RMF_MSG_MAX : 4'(`RMF_MSG_MAX - 4'd1);
      end
   end

   // A request is taken only while the sender is free
   assign reqReady = !mi.busy && !clearAny;
   assign loadRead = rdReq && reqReady;
   assign mi.load = loadRead || clearAny;
   assign mi.msg = msg;
   assign mi.len = len;
   assign mi.eoiEn = ctrl.eoiEn;

   ////////////////////////////////////////////////////////////////////////
   // Service request flags: ready, overrange, burst, OR group, error
   always_comb begin
      setV[0] = evOutReady && mask[0];
      setV[1] = evOverrange && (mask[0] || mask[1]);
      setV[2] = evEndBurst && mask[3];
      setV[3] = (evHighPeak && mask[4]) || (evLowPeak && mask[5]) ||
                (evHigh && mask[6]) || (evPass && mask[7]) ||
                (evLow && mask[8]) || (evLfac && mask[9]);
      setV[4] = evError && (mask[0] || mask[2]);
      clrV = 5'h00;
      // Data requests end with the last byte of a reading message
      if (mi.done && dataPend) begin
         clrV = clrV | 5'h13;
      end
      if (clearReqChar) begin
         clrV = clrV | 5'h0c;
      end
      // Set wins over a clrV clear, so an event in that clearing cycle survives
      next_flags = setV | (flags & ~clrV);
      if (clearAny) begin
         next_flags = 5'h00;
      end
   end

   // Marks a reading in flight whose last byte retires data requests
   always_comb begin
      next_dataPend = dataPend;
      if (mi.done) begin
         next_dataPend = 1'b0;
      end
      if (loadRead && !rdSelDreg) begin
         next_dataPend = 1'b1;
      end
      if (clearAny) begin
         next_dataPend = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         flags <= 5'h00;
         dataPend <= 1'b0;
      end else begin
         flags <= next_flags;
         dataPend <= next_dataPend;
      end
   end

   // Bit 7 is request; bits 8 and 5 (one-based) read as zero
   assign statusByte = {1'b0, |flags, flags[4], 1'b0,
                        flags[3], flags[2], flags[1], flags[0]};
   assign srqLine = |flags;

   ////////////////////////////////////////////////////////////////////////
   // Trigger and abort pulses to the measurement sequencer
   // The sequencer's busy level gates triggers; no queue, by design
   always_comb begin
      next_trigStart = getCmd && !trigBusy && !clearAny;
      next_abort = clearAny;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         trigStartQ <= 1'b0;
         abortQ <= 1'b0;
      end else begin
         trigStartQ <= next_trigStart;
         abortQ <= next_abort;
      end
   end

   assign trigStart = trigStartQ;
   assign measAbort = abortQ;
endmodule

// ### src/rmf_consts.svh
`ifndef RMF_CONSTS_SVH
`define RMF_CONSTS_SVH

// Register byte offsets on the APB bus
`define RMF_OFS_CTRL 8'h00
`define RMF_OFS_MASK 8'h04
`define RMF_OFS_STAT 8'h08

// Control register field positions and reset value
`define RMF_CTRL_LF 0
`define RMF_CTRL_EOI 1
`define RMF_CTRL_BIN 2
`define RMF_CTRL_HS 3
`define RMF_CTRL_EXT 4
`define RMF_CTRL_RESET 5'h03

// Mask digit write: low three bits are one octal digit, bit 3 starts anew
`define RMF_MASK_FIRST 3
`define RMF_MASK_RESET 12'h000

// Characters of the output messages
`define RMF_CH_PLUS 8'h2b
`define RMF_CH_MINUS 8'h2d
`define RMF_CH_POINT 8'h2e
`define RMF_CH_EXP 8'h45
`define RMF_CH_ZERO 8'h30
`define RMF_CH_CR 8'h0d
`define RMF_CH_LF 8'h0a
`define RMF_CH_RESET 8'h2a

// Fixed binary codes
`define RMF_HS_OVR_POS 16'h2900
`define RMF_HS_OVR_NEG 16'ha900
`define RMF_LIM_HIGH 8'h02
`define RMF_LIM_PASS 8'h01
`define RMF_LIM_LOW 8'hff

// Exponent limit and longest message
`define RMF_EXP_MAX 6'd18
`define RMF_MSG_MAX 4'd14

`endif

// ### src/rmf_pkg.sv
package rmf_pkg;
   typedef logic [13:0][7:0] rmf_msg_t;
   typedef enum logic {RMF_IDLE, RMF_SEND} rmf_send_state_t;
   typedef struct packed {
      logic extTrig;
      logic highSpeed;
      logic binSel;
      logic eoiEn;
      logic lfEn;
   } rmf_ctrl_t;
endpackage

// ### src/rmf_msg_if.sv
`timescale 1ns/100ps
interface rmf_msg_if;
   import rmf_pkg::*;
   logic load;
   rmf_msg_t msg;
   logic [3:0] len;
   logic eoiEn;
   logic busy;
   logic done;
   modport src (output load, msg, len, eoiEn, input busy, done);
   modport snk (input load, msg, len, eoiEn, output busy, done);
endinterface

// ### src/rmf_byte_sender.sv
`timescale 1ns/100ps
module rmf_byte_sender
   import rmf_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   rmf_msg_if.snk mi,
   output logic [7:0] busData,
   output logic busValid,
   output logic busEoi,
   input wire logic busReady
);
   rmf_send_state_t state, next_state;
   rmf_msg_t buffer, next_buffer;
   logic [3:0] left, next_left;
   logic eoiEn, next_eoiEn;
   logic take;

   ////////////////////////////////////////////////////////////////////////
   // Shift register: byte 0 always stands on the bus pins
   assign take = (state == RMF_SEND) && busReady;
   assign busValid = (state == RMF_SEND);
   assign busData = buffer[0];
   assign busEoi = busValid && eoiEn && (left == 4'd1);
   assign mi.busy = (state == RMF_SEND);
   assign mi.done = take && (left == 4'd1);

   // A load overrides any message in flight, so a clear aborts at once
   always_comb begin
      next_state = state;
      next_buffer = buffer;
      next_left = left;
      next_eoiEn = eoiEn;
      case (state)
         RMF_IDLE: begin
            if (mi.load) begin
               next_state = RMF_SEND;
            end
         end
         RMF_SEND: begin
            if (take) begin
               next_buffer = {8'h00, buffer[13:1]};
               next_left = 4'(left - 4'd1);
               if (left == 4'd1) begin
                  next_state = RMF_IDLE;
               end
            end
         end
         default: next_state = RMF_IDLE;
      endcase
      if (mi.load) begin
         next_state = RMF_SEND;
         next_buffer = mi.msg;
         next_left = mi.len;
         next_eoiEn = mi.eoiEn;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state <= RMF_IDLE;
         buffer <= '0;
         left <= 4'h0;
         eoiEn <= 1'b0;
      end else begin
         state <= next_state;
         buffer <= next_buffer;
         left <= next_left;
         eoiEn <= next_eoiEn;
      end
   end
endmodule

// ### sim/rmf_formatter_sva.sv
`timescale 1ns/100ps
`include "rmf_consts.svh"
module rmf_formatter_sva (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic [7:0] busData,
   input wire logic busValid,
   input wire logic busEoi,
   input wire logic busReady,
   input wire logic devClear,
   input wire logic resetChar,
   input wire logic clearReqChar,
   input wire logic getCmd,
   input wire logic trigBusy,
   input wire logic trigStart,
   input wire logic measAbort,
   input wire logic externalTriggerMode,
   input wire logic srqLine,
   input wire logic [7:0] statusByte
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   logic clr;
   ////////////////////////////////////////////////////////////////////////
   // Either clear source aborts whatever message is in flight
   assign clr = devClear || resetChar;
   a_apb_unmapped: assert property (psel && penable
      && paddr != `RMF_OFS_CTRL && paddr != `RMF_OFS_MASK
      && paddr != `RMF_OFS_STAT |-> pslverr)
      else $error("unmapped access without error");
   a_get_start: assert property (
      getCmd && !trigBusy && !clr |=> trigStart)
      else $error("trigger not started");
   a_get_ext: assert property (getCmd && !clr |=> externalTriggerMode)
      else $error("external trigger mode not entered");
   a_get_drop: assert property (getCmd && trigBusy |=> !trigStart)
      else $error("busy trigger not ignored");
   a_clear_star: assert property (clr |=> busValid
      && busData == `RMF_CH_RESET && measAbort && !externalTriggerMode)
      else $error("clear did not send reset character");
   a_bus_hold: assert property (
      busValid && !busReady && !clr |=> busValid && $stable(busData))
      else $error("byte dropped while stalled");
   a_eoi_last: assert property (
      busValid && busReady && busEoi && !clr |=> !busValid)
      else $error("byte after end mark");
   a_stat_zero: assert property (!statusByte[7] && !statusByte[4])
      else $error("unused status bit set");
   a_srq_hold: assert property (srqLine && !clr && !clearReqChar
      && !(busValid && busReady) |=> srqLine)
      else $error("service request dropped without a clear");
   a_rsv_fall: assert property ($fell(statusByte[6]) |->
      $past(clr || clearReqChar || (busValid && busReady)))
      else $error("request flag cleared without cause");
   c_get: cover property (getCmd && !trigBusy);
   c_clear: cover property (clr);
   c_last: cover property (busValid && busReady && busEoi);
   c_srq: cover property ($rose(srqLine));
endmodule

// ### sim/rmf_bus_ctrl.sv
`timescale 1ns/100ps
module rmf_bus_ctrl (
   input wire logic clock,
   input wire logic rstn,
   input wire logic stall,
   input wire logic [7:0] busData,
   input wire logic busValid,
   input wire logic busEoi,
   output logic busReady
);
   logic [7:0] q[$];
   logic e[$];
   logic [15:0] hsWord;
   // Take bytes; a stalling listener holds ready low for whole cycles
   always @(posedge clock) begin
      if (rstn && busValid && busReady) begin
         q.push_back(busData);
         e.push_back(busEoi);
         hsWord <= {busData, hsWord[15:8]}; // Later byte is high
      end
      busReady <= rstn && !stall;
   end
endmodule

// ### sim/test_reading_message_formatter_srq.sv
`timescale 1ns/100ps
`include "rmf_consts.svh"
module test_reading_message_formatter_srq;
   import rmf_pkg::*;
   logic clock, rstn, psel, penable, pwrite, pready, pslverr, rdReq;
   logic rdSelDreg, rdSign, rdHighZ, rdOverPos, rdOverNeg, rdResist;
   logic limitActive, reqReady, busValid, busEoi, busReady, devClear;
   logic resetChar, clearReqChar, getCmd, trigBusy, trigStart, measAbort;
   logic srqLine, externalTriggerMode, highSpeedMode, lineFeedEnable;
   logic endIdentifyEnable, binaryOutputSelect, stall, rerr, lf, eoi;
   logic [1:0] limitCode;
   logic [2:0] rdPoint;
   logic [3:0] dregMinor;
   logic [5:0] rdExp;
   logic [7:0] paddr, busData, statusByte, dregMajor;
   logic [9:0] ev;
   logic [15:0] rdHsValue, w;
   logic [23:0] rdDigits;
   logic [31:0] pwdata, prdata, rdBin4, rdat;
   logic [7:0] xq[$];
   int seed = 32'hfe52000b;
   int mismatches = 0;
   int total_checks = 0;
   int stallMode = 0;
   int c;
   rmf_formatter dut (.*, .evOutReady(ev[0]), .evOverrange(ev[1]),
      .evError(ev[2]), .evEndBurst(ev[3]), .evHighPeak(ev[4]),
      .evLowPeak(ev[5]), .evHigh(ev[6]), .evPass(ev[7]), .evLow(ev[8]),
      .evLfac(ev[9]));
   rmf_bus_ctrl ctl (.*);
   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Random listener stalls, or a full stall to hold a message in flight
   always @(posedge clock) stall <= stallMode == 2 || (stallMode == 1
      && rnd(3) == 0);
   function automatic int rnd(int n);
      return {$random(seed)} % n;
   endfunction
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   // One APB transfer; the idle edge first avoids double assignment
   task automatic apb(logic wv, logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wv;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(logic [7:0] a, logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("read data", x, rdat);
   endtask
   task automatic setc(logic [4:0] v);
      logic [4:0] m;
      apb(1'b1, `RMF_OFS_CTRL, {27'h0, v});
      lf = v[0];
      eoi = v[1];
      @(posedge clock);
      m = {externalTriggerMode, highSpeedMode, binaryOutputSelect,
         endIdentifyEnable, lineFeedEnable};
      chk("mode outputs", v, m);
   endtask
   task automatic randf();
      int v;
      logic [23:0] dg;
      v = rnd(64) - 32;
      for (int i = 0; i < 6; i++) dg[4 * i +: 4] = 4'(rnd(10));
      rdDigits <= dg;
      rdSign <= 1'(rnd(2));
      rdPoint <= 3'(1 + rnd(6));
      rdExp <= 6'(v > -3 && v < 3 ? 0 : v);
      rdHighZ <= rnd(4) == 0;
      rdBin4 <= $random(seed);
      rdHsValue <= 16'($random(seed)) & 16'hfffe;
      @(posedge clock);
   endtask
   function automatic void term();
      xq.push_back(8'h0d);
      if (lf) xq.push_back(8'h0a);
   endfunction
   // Sign, seven data characters, four exponent characters
   function automatic void exp_ascii();
      int e, m;
      xq = {rdSign ? 8'h2d : 8'h2b};
      for (int i = 0; i < 6; i++) begin
         if (i == rdPoint) xq.push_back(8'h2e);
         xq.push_back(i == 0 && rdHighZ ? 8'h30 : 8'h30 | rdDigits[23 - 4 * i
            -: 4]);
      end
      if (rdPoint == 6) xq.push_back(8'h2e);
      e = $signed(rdExp);
      e = e > 18 ? 18 : e < -18 ? -18 : e;
      m = (e < 0 ? -e : e) / 3 * 3;
      xq.push_back(8'h45);
      xq.push_back(e < 0 ? 8'h2d : 8'h2b);
      xq.push_back(8'h30 + 8'(m / 10));
      xq.push_back(8'h30 + 8'(m % 10));
      term();
   endfunction
   task automatic wait_cmp(string n);
      for (int k = 0; k < 400 && ctl.q.size() < xq.size(); k++)
         @(posedge clock);
      repeat (3) @(posedge clock);
      chk({n, " length"}, xq.size(), ctl.q.size());
      foreach (xq[i]) begin
         chk(n, xq[i], ctl.q[i]);
         chk({n, " end mark"}, eoi && i == xq.size() - 1, ctl.e[i]);
      end
   endtask
   task automatic send(string n);
      ctl.q.delete();
      ctl.e.delete();
      rdReq <= 1'b1;
      do @(posedge clock); while (reqReady !== 1'b1);
      rdReq <= 1'b0;
      wait_cmp(n);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {psel, penable, pwrite, rdReq, rdSelDreg, rdSign, rdHighZ, rdOverPos,
         rdOverNeg, rdResist, limitActive, devClear, resetChar, clearReqChar,
         getCmd, trigBusy, limitCode, rdPoint, dregMinor, rdExp, paddr,
         dregMajor, ev, rdHsValue, rdDigits, pwdata, rdBin4} = '0;
      rstn = 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rdc(`RMF_OFS_CTRL, 32'h03);
      rdc(`RMF_OFS_MASK, 32'h0);
      rdc(`RMF_OFS_STAT, 32'h0);
      apb(1'b1, 8'h0c, 32'h1f);
      chk("unmapped error", 1, rerr);
      rdc(`RMF_OFS_CTRL, 32'h03);
      stallMode = 1;
      for (int i = 0; i < 8; i++) begin
         setc(5'(i % 4));
         randf();
         exp_ascii();
         send("ascii");
      end
      setc(5'h07);
      randf();
      xq = {rdBin4[31:24], rdBin4[23:16], rdBin4[15:8], rdBin4[7:0]};
      send("four byte");
      // Plain, resistance, positive and negative overrange at high speed
      for (int i = 0; i < 4; i++) begin
         setc(5'h0f);
         rdResist <= i == 1;
         rdOverPos <= i == 2;
         rdOverNeg <= i == 3;
         randf();
         w = i == 2 ? 16'h2900 : i == 3 ? 16'ha900 : rdHsValue;
         w[15] = w[15] | i == 1;
         xq = {w[7:0], w[15:8]};
         send("two byte");
         chk("two byte word", w, ctl.hsWord);
      end
      {rdResist, rdOverPos, rdOverNeg} <= '0;
      limitActive <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         setc({2'b00, i[2], 2'b11});
         limitCode <= i[1:0];
         @(posedge clock);
         c = i[1:0] == 1 ? 2 : i[1:0] == 2 ? 1 : 0;
         xq = {c == 2 ? 8'h02 : c == 1 ? 8'h01 : 8'hff};
         if (!i[2]) begin
            xq = {c == 0 ? 8'h2d : 8'h2b, 8'h30 + 8'(c == 0 ? 1 : c)};
            term();
         end
         send("limit");
      end
      limitActive <= 1'b0;
      setc(5'h03);
      rdSelDreg <= 1'b1;
      // Single-digit register number first, then a two-digit one
      for (int i = 0; i < 2; i++) begin
         dregMajor <= {4'(i * (1 + rnd(9))), 4'(rnd(10))};
         dregMinor <= 4'(rnd(10));
         @(posedge clock);
         xq = {8'h30 | dregMajor[3:0], 8'h2e, 8'h30 | dregMinor};
         if (i == 1) xq.push_front(8'h30 | dregMajor[7:4]);
         term();
         send("register number");
      end
      rdSelDreg <= 1'b0;
      // Clear in mid-message while the listener stalls
      for (int i = 0; i < 2; i++) begin
         stallMode = 2;
         setc(5'h0b);
         randf();
         ctl.q.delete();
         ctl.e.delete();
         rdReq <= 1'b1;
         @(posedge clock);
         rdReq <= 1'b0;
         repeat (3) @(posedge clock);
         if (i == 1) resetChar <= 1'b1;
         else devClear <= 1'b1;
         @(posedge clock);
         {devClear, resetChar} <= '0;
         stallMode = 1;
         xq = {8'h2a};
         wait_cmp("clear");
         rdc(`RMF_OFS_CTRL, 32'h03);
      end
      for (int i = 0; i < 3; i++) begin
         setc(i == 1 ? 5'h13 : 5'h03);
         repeat (4) @(posedge clock); // Settle after commands
         trigBusy <= i == 2;
         getCmd <= 1'b1;
         @(posedge clock);
         getCmd <= 1'b0;
         @(posedge clock);
         chk("trigger start", i != 2, trigStart);
         rdc(`RMF_OFS_CTRL, 32'h13);
      end
      trigBusy <= 1'b0;
      apb(1'b1, `RMF_OFS_MASK, 32'h9);
      apb(1'b1, `RMF_OFS_MASK, 32'h4);
      rdc(`RMF_OFS_MASK, 32'o14);
      for (int i = 0; i < 10; i++) begin
         for (int d = 3; d >= 0; d--)
            apb(1'b1, `RMF_OFS_MASK, {d == 3, 3'((1 << i) >> (3 * d))});
         ev <= 10'h1 << i;
         @(posedge clock);
         ev <= '0;
         @(posedge clock);
         c = i == 0 ? 1 : i == 1 ? 2 : i == 2 ? 32 : i == 3 ? 4 : 8;
         chk("status", 8'h40 | 8'(c), statusByte);
         chk("service line", 1, srqLine);
         clearReqChar <= 1'b1;
         @(posedge clock);
         clearReqChar <= 1'b0;
         @(posedge clock);
         chk("service hold", i < 3, srqLine);
         if (i < 3) begin
            randf();
            exp_ascii();
            send("data request");
         end
         chk("service clear", 0, srqLine);
      end
      complete_run();
   end
endmodule
bind rmf_formatter rmf_formatter_sva chk_i (.*);
